// >>> monitor_cmd_pkg.sv
// package: command codes, field positions and carrier types for the monitor command block
//==============================================================================
package monitor_cmd_pkg;
	localparam int          OP_W          = 11;
	localparam int          BYTE_W        = 8;
	localparam int          GROUP_BYTES   = 6;
	localparam int          RET_W         = 48;
	localparam int          PEC_W         = 16;
	localparam logic [6:0]  LEN_GROUP     = 7'h06;
	localparam logic [6:0]  LEN_BULK_ONE  = 7'h20;
	localparam logic [6:0]  LEN_BULK_TWO  = 7'h40;
	localparam logic [6:0]  LEN_BULK_AUX  = 7'h44;
	localparam logic [9:0]  BIT_CMD_END   = 10'h00F;
	localparam logic [9:0]  BIT_PEC_END   = 10'h01F;
	localparam logic [9:0]  BIT_DATA_END  = 10'h04F;
	localparam logic [9:0]  BIT_DPEC_END  = 10'h05F;
	localparam logic [9:0]  BIT_MAX       = 10'h3FF;
	localparam logic [10:0] OP_HEARTBEAT  = 11'h043;
	localparam logic [10:0] OP_LPM_OFF    = 11'h040;
	localparam logic [10:0] OP_LPM_ON     = 11'h041;
	localparam logic [10:0] OP_SNAP       = 11'h02D;
	localparam logic [10:0] OP_RELEASE    = 11'h02F;
	localparam logic [10:0] OP_CNT_CLEAR  = 11'h02E;
	localparam logic [10:0] OP_RET_UNLOCK = 11'h038;
	localparam logic [10:0] OP_RET_WRITE  = 11'h039;
	localparam logic [10:0] OP_RET_READ   = 11'h03A;
	localparam logic [10:0] OP_ID_READ    = 11'h02C;
	localparam logic [10:0] CELL_MASK     = 11'h668;
	localparam logic [10:0] CELL_VALUE    = 11'h260;
	localparam logic [10:0] SV_MASK       = 11'h76C;
	localparam logic [10:0] SV_VALUE      = 11'h168;
	localparam logic [10:0] AUX_MASK      = 11'h630;
	localparam logic [10:0] AUX_VALUE     = 11'h410;
	localparam logic [10:0] AUX2_MASK     = 11'h7F0;
	localparam logic [10:0] AUX2_VALUE    = 11'h400;
	localparam int          POS_REPEAT    = 7;
	localparam int          POS_DISCHARGE = 4;
	localparam int          POS_FCLEAR    = 2;
	localparam int          POS_AUX_WIRE  = 8;
	localparam int          POS_PULL      = 7;
	localparam int          POS_CH_HIGH   = 6;
	localparam int          POS_ERR       = 0;
	localparam logic [4:0]  CH_RESERVED   = 5'h17;
	localparam logic [7:0]  CORRUPT_MASK  = 8'hFF;
	typedef enum logic [2:0] {rk_none, rk_sid, rk_ret, rk_stat_c,
		rk_bulk_one, rk_bulk_two, rk_bulk_aux} read_kind_type;
	typedef enum logic [2:0] {cv_none, cv_cell, cv_svolt, cv_aux, cv_aux2} conv_kind_type;
	typedef struct packed {
		logic       repeat_measure_bit;
		logic [1:0] wire_break_detect;
		logic       pull_direction_bit;
		logic       discharge_permit_bit;
		logic       filter_clear_bit;
		logic [4:0] aux_channel_sel;
	} conv_cmd_type;
endpackage

// >>> monitor_cmd_readback_ctrl.sv
// module: command decode, counter, snapshot, retention and readback for the monitor
`timescale 1ns/1ps
module monitor_cmd_readback_ctrl #(
	parameter logic [47:0] UNIQUE_ID     = 48'h0000_5A5A_1234, // arbitrary value
	parameter logic [15:0] PEC_POLY      = 16'h8005,
	parameter logic [15:0] PEC_SEED      = 16'h0010,
	parameter logic [10:0] OP_BULK_CELL  = 11'h00C,
	parameter logic [10:0] OP_BULK_AVG   = 11'h04C,
	parameter logic [10:0] OP_BULK_FILT  = 11'h018,
	parameter logic [10:0] OP_BULK_SV    = 11'h010,
	parameter logic [10:0] OP_BULK_CSV   = 11'h014,
	parameter logic [10:0] OP_BULK_ASV   = 11'h044,
	parameter logic [10:0] OP_BULK_AUXST = 11'h035,
	parameter logic [10:0] OP_STAT_C     = 11'h032,
	parameter int          ALERT_W       = 8,
	parameter int          CNT_W         = 6
) (
	// system clock and reset
	input  wire logic                          clock,
	input  wire logic                          reset,
	// serial link
	input  wire logic                          link_clock,
	input  wire logic                          chip_select_n,
	input  wire logic                          serial_in,
	output logic                               serial_out,
	output logic                               serial_out_en,
	// result store port, link clock
	output monitor_cmd_pkg::read_kind_type     read_kind,
	output logic [6:0]                         read_byte_index,
	input  wire logic [7:0]                    read_byte_data,
	// chip side, system clock
	input  wire logic                          serial_fault_enable,
	input  wire logic [ALERT_W-1:0]            alert_flags,
	output monitor_cmd_pkg::conv_cmd_type      conv_cmd,
	output monitor_cmd_pkg::conv_kind_type     conv_start,
	output logic                               heartbeat_pulse,
	output logic                               lowpower_monitor_mode,
	output logic [CNT_W-1:0]                   command_count,
	output logic                               results_frozen,
	output logic                               poll_allowed,
	output logic [ALERT_W-1:0]                 status_alerts,
	output logic [47:0]                        retention_data
);
	import monitor_cmd_pkg::*;

	function automatic logic [15:0] pec_step(input logic [15:0] crc, input logic b);
		pec_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? PEC_POLY : 16'h0000);
	endfunction

	function automatic logic [6:0] resp_len(input read_kind_type k);
		unique case (k)
			rk_bulk_one: resp_len = LEN_BULK_ONE;
			rk_bulk_two: resp_len = LEN_BULK_TWO;
			rk_bulk_aux: resp_len = LEN_BULK_AUX;
			default:     resp_len = LEN_GROUP;
		endcase
	endfunction

	//==========================================================================
	// link side: frame reception
	logic              frame_idle;
	logic [9:0]        bit_cnt_r;
	logic [15:0]       rx_sh_r;
	logic [15:0]       rx_next;
	logic [15:0]       crc_r;
	logic [15:0]       crc_in;
	logic [15:0]       pec_ref_r;
	logic [10:0]       cmd_r;
	logic              cmd_ok_r;
	logic [47:0]       data_r;
	logic              data_full_r;
	logic              data_ok_r;
	logic              err_r;
	logic              fault_meta_r;
	logic              fault_sync_r;
	read_kind_type     kind_nxt;
	localparam logic [10:0] ERR_BIT = 11'h001 << POS_ERR;

	assign frame_idle = reset | chip_select_n;
	assign rx_next    = {rx_sh_r[14:0], serial_in};
	assign crc_in     = (bit_cnt_r == 10'h000 || bit_cnt_r == BIT_PEC_END + 10'h001)
		? PEC_SEED : crc_r;

	always_ff @(posedge link_clock or posedge frame_idle) begin
		if (frame_idle) begin
			bit_cnt_r <= 10'h000;
		end else if (bit_cnt_r != BIT_MAX) begin
			bit_cnt_r <= bit_cnt_r + 10'h001;
		end
	end

	always_ff @(posedge link_clock or posedge reset) begin
		if (reset) begin
			rx_sh_r <= 16'h0000;
			crc_r   <= 16'h0000;
		end else begin
			rx_sh_r <= rx_next;
			crc_r   <= pec_step(crc_in, serial_in);
		end
	end

	// record of the frame, held steady while the select is high
	always_ff @(posedge link_clock or posedge reset) begin
		if (reset) begin
			pec_ref_r   <= 16'h0000;
			cmd_r       <= 11'h000;
			cmd_ok_r    <= 1'b0;
			data_r      <= 48'h0;
			data_full_r <= 1'b0;
			data_ok_r   <= 1'b0;
			err_r       <= 1'b0;
		end else begin
			if (bit_cnt_r == 10'h000) begin
				cmd_ok_r    <= 1'b0;
				data_full_r <= 1'b0;
				data_ok_r   <= 1'b0;
			end
			if (bit_cnt_r == BIT_CMD_END || bit_cnt_r == BIT_DATA_END) begin
				pec_ref_r <= pec_step(crc_in, serial_in);
			end
			if (bit_cnt_r == BIT_CMD_END) begin
				cmd_r <= rx_next[OP_W-1:0];
				err_r <= rx_next[POS_ERR];
			end
			if (bit_cnt_r == BIT_PEC_END) begin
				cmd_ok_r <= (rx_next == pec_ref_r);
			end
			if (bit_cnt_r > BIT_PEC_END && bit_cnt_r <= BIT_DATA_END) begin
				data_r <= {data_r[46:0], serial_in};
			end
			if (bit_cnt_r == BIT_DATA_END) begin
				data_full_r <= 1'b1;
			end
			if (bit_cnt_r == BIT_DPEC_END) begin
				data_ok_r <= (rx_next == pec_ref_r);
			end
		end
	end

	// fault enable level into the link domain
	always_ff @(posedge link_clock or posedge reset) begin
		if (reset) begin
			fault_meta_r <= 1'b0;
			fault_sync_r <= 1'b0;
		end else begin
			fault_meta_r <= serial_fault_enable;
			fault_sync_r <= fault_meta_r;
		end
	end

	//==========================================================================
	// link side: readback
	logic [15:0]       tx_sh_r;
	logic [15:0]       tx_crc_r;
	logic              tx_active_r;
	logic              tx_pec_r;
	logic [6:0]        tx_pos_r;
	logic [6:0]        tx_len;
	logic [7:0]        src_byte;
	logic [47:0]       id_sh;
	logic [47:0]       ret_sh;

	always_comb begin
		unique case (rx_next[OP_W-1:0])
			OP_ID_READ:    kind_nxt = rk_sid;
			OP_RET_READ:   kind_nxt = rk_ret;
			OP_BULK_CELL,
			OP_BULK_AVG,
			OP_BULK_FILT,
			OP_BULK_SV:    kind_nxt = rk_bulk_one;
			OP_BULK_CSV,
			OP_BULK_ASV:   kind_nxt = rk_bulk_two;
			OP_BULK_AUXST: kind_nxt = rk_bulk_aux;
			default:       kind_nxt = rk_none;
		endcase
		// the error-inject bit rides inside the status C opcode
		if ((rx_next[OP_W-1:0] & ~ERR_BIT) == (OP_STAT_C & ~ERR_BIT)) begin
			kind_nxt = rk_stat_c;
		end
	end

	assign tx_len = resp_len(read_kind);
	assign id_sh  = UNIQUE_ID >> {tx_pos_r, 3'b000};
	assign ret_sh = retention_data << {tx_pos_r, 3'b000};

	// bytes go out as stored, reserved bits included, except status C bytes inverted when err_r and fault_sync_r are set; all under the check code
	always_comb begin
		unique case (read_kind)
			rk_sid:    src_byte = id_sh[7:0];
			rk_ret:    src_byte = ret_sh[47:40];
			rk_stat_c: src_byte = (err_r && fault_sync_r)
				? (read_byte_data ^ CORRUPT_MASK) : read_byte_data;
			default:   src_byte = read_byte_data;
		endcase
	end

	always_ff @(posedge link_clock or posedge frame_idle) begin
		if (frame_idle) begin
			read_kind <= rk_none;
		end else if (bit_cnt_r == BIT_CMD_END) begin
			read_kind <= kind_nxt;
		end
	end

	always_ff @(posedge link_clock or posedge frame_idle) begin
		if (frame_idle) begin
			tx_sh_r     <= 16'h0000;
			tx_crc_r    <= 16'h0000;
			tx_active_r <= 1'b0;
			tx_pec_r    <= 1'b0;
			tx_pos_r    <= 7'h00;
		end else if (bit_cnt_r == BIT_PEC_END) begin
			if (rx_next == pec_ref_r && read_kind != rk_none) begin
				tx_active_r <= 1'b1;
				tx_sh_r     <= {src_byte, 8'h00};
				tx_pos_r    <= 7'h01;
				tx_crc_r    <= PEC_SEED;
			end
		end else if (tx_active_r) begin
			if (!tx_pec_r) begin
				tx_crc_r <= pec_step(tx_crc_r, tx_sh_r[15]);
			end
			if (bit_cnt_r[2:0] != 3'h7) begin
				tx_sh_r <= {tx_sh_r[14:0], 1'b0};
			end else if (tx_pos_r < tx_len) begin
				tx_sh_r  <= {src_byte, 8'h00};
				tx_pos_r <= tx_pos_r + 7'h01;
			end else if (!tx_pec_r) begin
				tx_sh_r  <= pec_step(tx_crc_r, tx_sh_r[15]);
				tx_pec_r <= 1'b1;
				tx_pos_r <= tx_pos_r + 7'h01;
			end else if (tx_pos_r == tx_len + 7'h01) begin
				tx_sh_r  <= {tx_sh_r[14:0], 1'b0};
				tx_pos_r <= tx_pos_r + 7'h01;
			end else begin
				tx_active_r <= 1'b0;
			end
		end
	end

	assign serial_out      = tx_sh_r[15];
	assign serial_out_en   = tx_active_r;
	assign read_byte_index = tx_pos_r;

	//==========================================================================
	// system side: frame end detection
	logic              cs_meta_r;
	logic              cs_sync_r;
	logic              cs_prev_r;
	logic              commit;
	logic              valid_cmd;
	logic              is_write;
	logic              hb_cmd;
	logic              counts;
	logic              unlocked_r;
	logic [ALERT_W-1:0] pending_r;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cs_meta_r <= 1'b1;
			cs_sync_r <= 1'b1;
			cs_prev_r <= 1'b1;
		end else begin
			cs_meta_r <= chip_select_n;
			cs_sync_r <= cs_meta_r;
			cs_prev_r <= cs_sync_r;
		end
	end

	assign commit    = cs_sync_r & ~cs_prev_r;
	assign valid_cmd = commit & cmd_ok_r;
	assign is_write  = (cmd_r == OP_RET_WRITE);
	assign hb_cmd    = (cmd_r == OP_HEARTBEAT);
	assign counts    = valid_cmd && (!is_write || data_ok_r)
		&& !(hb_cmd && !lowpower_monitor_mode);

	//==========================================================================
	// system side: command counter
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			command_count <= '0;
		end else if (valid_cmd && cmd_r == OP_CNT_CLEAR) begin
			command_count <= '0;
		end else if (counts) begin
			command_count <= command_count + 1'b1;
		end
	end

	//==========================================================================
	// system side: low-power mode and heartbeat
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			lowpower_monitor_mode <= 1'b0;
			heartbeat_pulse       <= 1'b0;
		end else begin
			heartbeat_pulse <= valid_cmd && hb_cmd && lowpower_monitor_mode;
			if (valid_cmd && cmd_r == OP_LPM_ON) begin
				lowpower_monitor_mode <= 1'b1;
			end else if (valid_cmd && cmd_r == OP_LPM_OFF) begin
				lowpower_monitor_mode <= 1'b0;
			end
		end
	end

	//==========================================================================
	// system side: conversion commands
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			conv_cmd   <= '0;
			conv_start <= cv_none;
		end else begin
			conv_start <= cv_none;
			if (valid_cmd && (cmd_r & CELL_MASK) == CELL_VALUE) begin
				conv_start                    <= cv_cell;
				conv_cmd                      <= '0;
				conv_cmd.repeat_measure_bit   <= cmd_r[POS_REPEAT];
				conv_cmd.wire_break_detect    <= cmd_r[1:0];
				conv_cmd.discharge_permit_bit <= cmd_r[POS_DISCHARGE];
				conv_cmd.filter_clear_bit     <= cmd_r[POS_FCLEAR];
			end else if (valid_cmd && (cmd_r & SV_MASK) == SV_VALUE) begin
				conv_start                    <= cv_svolt;
				conv_cmd                      <= '0;
				conv_cmd.repeat_measure_bit   <= cmd_r[POS_REPEAT];
				conv_cmd.wire_break_detect    <= cmd_r[1:0];
				conv_cmd.discharge_permit_bit <= cmd_r[POS_DISCHARGE];
			end else if (valid_cmd && (cmd_r & AUX_MASK) == AUX_VALUE
				&& {cmd_r[POS_CH_HIGH], cmd_r[3:0]} != CH_RESERVED) begin
				conv_start                  <= cv_aux;
				conv_cmd                    <= '0;
				conv_cmd.wire_break_detect  <= {1'b0, cmd_r[POS_AUX_WIRE]};
				conv_cmd.pull_direction_bit <= cmd_r[POS_PULL];
				conv_cmd.aux_channel_sel    <= {cmd_r[POS_CH_HIGH], cmd_r[3:0]};
			end else if (valid_cmd && (cmd_r & AUX2_MASK) == AUX2_VALUE) begin
				conv_start               <= cv_aux2;
				conv_cmd                 <= '0;
				conv_cmd.aux_channel_sel <= {1'b0, cmd_r[3:0]};
			end
		end
	end

	//==========================================================================
	// system side: snapshot freeze and alert hold-over
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			results_frozen <= 1'b0;
			poll_allowed   <= 1'b1;
		end else if (valid_cmd && cmd_r == OP_SNAP) begin
			results_frozen <= 1'b1;
			poll_allowed   <= 1'b0;
		end else if (valid_cmd && cmd_r == OP_RELEASE) begin
			results_frozen <= 1'b0;
			poll_allowed   <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			status_alerts <= '0;
			pending_r     <= '0;
		end else if (results_frozen && valid_cmd && cmd_r == OP_RELEASE) begin
			status_alerts <= pending_r | alert_flags;
			pending_r     <= '0;
		end else if (results_frozen) begin
			pending_r <= pending_r | alert_flags;
		end else begin
			status_alerts <= alert_flags;
		end
	end

	//==========================================================================
	// system side: retention bytes
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			unlocked_r     <= 1'b0;
			retention_data <= '0;
		end else if (valid_cmd) begin
			unlocked_r <= (cmd_r == OP_RET_UNLOCK);
			if (is_write && unlocked_r && data_full_r) begin
				retention_data <= data_r;
			end
		end
	end

	//==========================================================================
	// checks
	chk_bad_pec_quiet: assert property (@(posedge clock) disable iff (reset)
		(commit && !cmd_ok_r) |=> $stable(command_count) && conv_start == cv_none)
		else $error("bad command check changed state");
	chk_write_needs_data: assert property (@(posedge clock) disable iff (reset)
		(commit && cmd_ok_r && is_write && !data_ok_r) |=> $stable(command_count))
		else $error("write counted without valid data");
	chk_snap_counts: assert property (@(posedge clock) disable iff (reset)
		(valid_cmd && (cmd_r == OP_SNAP || cmd_r == OP_RELEASE))
		|=> command_count == $past(command_count) + 1'b1)
		else $error("snapshot command not counted");
	chk_snap_freezes: assert property (@(posedge clock) disable iff (reset)
		(valid_cmd && cmd_r == OP_SNAP) |=> results_frozen && !poll_allowed)
		else $error("snapshot did not freeze");
	chk_freeze_holds: assert property (@(posedge clock) disable iff (reset)
		(results_frozen && !(valid_cmd && cmd_r == OP_RELEASE)) |=> results_frozen)
		else $error("freeze left without release");
	chk_alert_release: assert property (@(posedge clock) disable iff (reset)
		(results_frozen && valid_cmd && cmd_r == OP_RELEASE)
		|=> (status_alerts & $past(pending_r)) == $past(pending_r))
		else $error("held alerts lost at release");
	chk_hb_gated: assert property (@(posedge clock) disable iff (reset)
		heartbeat_pulse |-> $past(lowpower_monitor_mode))
		else $error("heartbeat outside low-power mode");
	chk_ret_locked: assert property (@(posedge clock) disable iff (reset)
		(valid_cmd && is_write && !unlocked_r) |=> $stable(retention_data))
		else $error("retention written while locked");
	chk_cell_fields: assert property (@(posedge clock) disable iff (reset)
		(conv_start == cv_cell) |-> conv_cmd.repeat_measure_bit == $past(cmd_r[POS_REPEAT])
		&& conv_cmd.wire_break_detect == $past(cmd_r[1:0]))
		else $error("cell command fields wrong");
	chk_tx_len: assert property (@(posedge link_clock) disable iff (frame_idle)
		(tx_active_r && tx_pec_r) |-> tx_pos_r > tx_len)
		else $error("check code sent before data ended");
	cov_snap_release: cover property (@(posedge clock) disable iff (reset)
		results_frozen ##[1:1000] !results_frozen);
	cov_ret_write: cover property (@(posedge clock) disable iff (reset)
		valid_cmd && is_write && unlocked_r);
	cov_bulk_aux: cover property (@(posedge link_clock) disable iff (frame_idle)
		tx_pec_r && read_kind == rk_bulk_aux);
endmodule

// >>> link_host.sv
// host controller model driving the serial link
`timescale 1ns/1ps
module link_host (
	// serial link
	output logic      link_clock,
	output logic      chip_select_n,
	output logic      serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_en
);
	logic [7:0] rx_q[$];
	int         en_cycles;
	initial begin
		link_clock = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
	end
	//==========================================================================
	// check code, reserved bits included
	function automatic logic [15:0] packet_check_code(input logic [47:0] d, input int n);
		logic [15:0] c;
		c = 16'h0010;
		for (int i = n - 1; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
		end
		return c;
	endfunction
	// one frame to a single device; link clock stands still outside frames
	task automatic frame(input logic [15:0] cmd, input logic [47:0] dat,
		input logic [1:0] bad, input int len);
		logic [95:0] w;
		logic [7:0]  b;
		int          n;
		w = {cmd, packet_check_code({32'h0, cmd}, 16) ^ {15'h0, bad[0]}, dat, packet_check_code(dat, 48) ^ {15'h0, bad[1]}};
		n = (len > 0) ? 31 + 8 * (len + 2) : 96;
		rx_q.delete();
		en_cycles = 0;
		b = 8'h00;
		chip_select_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_in = (i < 96) ? w[95 - i] : ~serial_in;
			#6 link_clock = 1'b1;
			#6 link_clock = 1'b0;
			en_cycles += int'(serial_out_en);
			b = {b[6:0], serial_out};
			if (i >= 31 && (i - 31) % 8 == 7) rx_q.push_back(b);
		end
		#6 chip_select_n = 1'b1;
		serial_in = ~serial_in;
	endtask
endmodule

// >>> tb_top.sv
// self-checking testbench for the monitor command block
`timescale 1ns/1ps
module tb_top;
	import monitor_cmd_pkg::*;
	localparam logic [47:0] ID = 48'hC3A5_0F1E_2D96; // arbitrary value
	localparam logic [10:0] OP_STAT_C = 11'h032; // status C read opcode given to the dut
	logic          clock, reset, serial_fault_enable, hb_seen;
	logic [7:0]    alert_flags, status_alerts, alert_seen;
	logic [10:0]   op;
	logic [47:0]   rdat, retention_data;
	logic [5:0]    command_count, cnt0;
	wire  [5:0]    delta = command_count - cnt0;
	wire           link_clock, chip_select_n, serial_in, serial_out, serial_out_en;
	wire  [7:0]    read_byte_data;
	logic [6:0]    read_byte_index;
	logic          heartbeat_pulse, lowpower_monitor_mode, results_frozen, poll_allowed;
	read_kind_type read_kind;
	conv_cmd_type  conv_cmd;
	conv_kind_type conv_start, last_start;
	int            seed, num_errors, n_tests;
	logic [10:0]   bo[7] = '{11'h00C, 11'h04C, 11'h018, 11'h010, 11'h014, 11'h044, 11'h035};
	int            bl[7] = '{32, 32, 32, 32, 64, 64, 68};
	// result store: each byte marks its own index
	assign read_byte_data = {1'b1, read_byte_index};
	always #20 clock = ~clock;
	always @(posedge clock) begin
		if (conv_start !== cv_none) last_start <= conv_start;
		if (heartbeat_pulse) hb_seen <= 1'b1;
		alert_seen <= alert_seen | status_alerts;
	end
	link_host host (.link_clock, .chip_select_n, .serial_in, .serial_out, .serial_out_en);
	monitor_cmd_readback_ctrl #(.UNIQUE_ID(ID), .OP_STAT_C(OP_STAT_C)) dut (.clock, .reset,
		.link_clock,
		.chip_select_n, .serial_in, .serial_out, .serial_out_en, .read_kind, .read_byte_index,
		.read_byte_data, .serial_fault_enable, .alert_flags, .conv_cmd, .conv_start,
		.heartbeat_pulse, .lowpower_monitor_mode, .command_count, .results_frozen,
		.poll_allowed, .status_alerts, .retention_data);
	//==========================================================================
	// helpers
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic send(input logic [10:0] o, input logic [47:0] d, input logic [1:0] b,
		input int len);
		cnt0 = command_count;
		last_start = cv_none;
		hb_seen = 1'b0;
		alert_seen = 8'h00;
		host.frame({5'h00, o}, d, b, len);
		repeat (10) @(posedge clock);
		#1;
	endtask
	task automatic rx_chk(input logic [47:0] e);
		for (int k = 0; k < 6; k++) chk("reply byte", host.rx_q[k], e[47 - 8 * k -: 8]);
		chk("reply check", {host.rx_q[6], host.rx_q[7]}, host.packet_check_code(e, 48));
	endtask
	task automatic complete_run();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		num_errors++;
		complete_run();
	end
	//==========================================================================
	// main sequence
	initial begin
		seed = 32'h7625;
		clock = 1'b0;
		reset = 1'b1;
		serial_fault_enable = 1'b0;
		alert_flags = 8'h00;
		num_errors = 0;
		n_tests = 0;
		repeat (16) @(posedge clock);
		#1 reset = 1'b0;
		repeat (4) @(posedge clock);
		#1;
		send(OP_ID_READ, 48'h0, 2'b00, 6);
		chk("id length", host.en_cycles, 64);
		rx_chk({<<8{ID}});
		send(OP_ID_READ, 48'h0, 2'b01, 6);
		chk("refused reply", host.en_cycles, 0);
		for (int k = 0; k < 4; k++) begin
			serial_fault_enable = k[1];
			send(OP_STAT_C | 11'(k[0]), 48'h0, 2'b00, 6);
			rx_chk(48'h808182838485 ^ {48{k == 3}});
		end
		for (int k = 0; k < 7; k++) begin
			send(bo[k], 48'h0, 2'b00, bl[k]);
			chk("bulk length", host.en_cycles, 8 * (bl[k] + 2));
		end
		for (int k = 0; k < 8; k++) begin
			op = CELL_VALUE | (11'($random(seed)) & ~CELL_MASK);
			op[1:0] = k[1:0];
			send(op, 48'h0, 2'b00, 0);
			chk("cell", {last_start, conv_cmd & 11'h760},
				{cv_cell, op[7], op[1:0], 1'b0, op[4], op[2], 5'h00});
		end
		for (int k = 0; k < 4; k++) begin
			op = SV_VALUE | (11'($random(seed)) & ~SV_MASK);
			send(op, 48'h0, 2'b00, 0);
			chk("svolt", {last_start, conv_cmd & 11'h760},
				{cv_svolt, op[7], op[1:0], 1'b0, op[4], 1'b0, 5'h00});
		end
		for (int c = 0; c < 24; c++) begin
			op = AUX_VALUE | {2'b00, 1'b1, 1'($random(seed)), c[4], 2'b00, c[3:0]};
			if (c < 10 || c > 15) send(op, 48'h0, 2'b00, 0);
			if (c == 23) chk("aux reserved", last_start, cv_none);
			else if (c < 10 || c > 15) chk("aux", {last_start, conv_cmd & 11'h79F},
				{cv_aux, 1'b0, 2'b01, op[7], 2'b00, op[6], op[3:0]});
		end
		for (int k = 0; k < 4; k++) begin
			op = AUX2_VALUE | (11'($random(seed)) & 11'h00F);
			send(op, 48'h0, 2'b00, 0);
			chk("aux2", {last_start, conv_cmd}, {cv_aux2, 7'h00, op[3:0]});
		end
		send(OP_SNAP, 48'h0, 2'b01, 0);
		chk("refused snap", {delta, results_frozen}, 7'h00);
		send(OP_SNAP, 48'h0, 2'b00, 0);
		chk("snap", {delta, results_frozen, poll_allowed}, {6'h01, 2'b10});
		alert_flags = 8'h5A;
		repeat (3) @(posedge clock);
		#1 alert_flags = 8'h00;
		send(OP_SNAP, 48'h0, 2'b00, 0);
		chk("resnap", {delta, results_frozen, alert_seen}, {6'h01, 9'h100});
		send(OP_RELEASE, 48'h0, 2'b00, 0);
		chk("release", {delta, results_frozen, alert_seen}, {6'h01, 9'h05A});
		send(OP_LPM_OFF, 48'h0, 2'b00, 0);
		send(OP_HEARTBEAT, 48'h0, 2'b00, 0);
		chk("idle beat", {delta, hb_seen}, 7'h00);
		send(OP_LPM_ON, 48'h0, 2'b00, 0);
		send(OP_HEARTBEAT, 48'h0, 2'b00, 0);
		chk("live beat", {delta, hb_seen}, 7'h03);
		rdat = 48'({$random(seed), $random(seed)});
		send(OP_RET_UNLOCK, 48'h0, 2'b00, 0);
		send(OP_RET_WRITE, rdat, 2'b10, 0);
		chk("bad data write", {delta, retention_data}, {6'h00, rdat});
		send(OP_RET_UNLOCK, 48'h0, 2'b00, 0);
		send(OP_RET_WRITE, ~rdat, 2'b00, 0);
		chk("good write", {delta, retention_data}, {6'h01, ~rdat});
		send(OP_RET_UNLOCK, 48'h0, 2'b00, 0);
		send(OP_ID_READ, 48'h0, 2'b00, 6);
		send(OP_RET_WRITE, rdat, 2'b00, 0);
		send(OP_RET_READ, 48'h0, 2'b00, 6);
		rx_chk(~rdat);
		send(OP_CNT_CLEAR, 48'h0, 2'b00, 0);
		chk("count clear", command_count, 6'h00);
		complete_run();
	end
endmodule
